// >>> nibble_exec_pkg.sv
// constants, widths, register offsets and opcode set for the nibble transfer unit
// assumes one core clock and a decoder that presents one instruction per cycle
package nibble_exec_pkg;

  // datapath widths
  localparam int ACC_W = 4;
  localparam int D_W = 3;
  localparam int BANK_W = 2;
  localparam int FILE_W = 4;
  localparam int DIGIT_W = 4;
  localparam int SI_W = 3;
  localparam int IMM_W = 8;
  localparam int RAM_AW = BANK_W + FILE_W + DIGIT_W;

  // immediate field positions
  localparam int IMM_X_HI = 7;
  localparam int IMM_X_LO = 4;
  localparam int IMM_Y_HI = 3;
  localparam int IMM_Y_LO = 0;
  localparam int IMM_Z_HI = 1;
  localparam int IMM_J_HI = 3;

  // digit-select skip values and step
  localparam logic [DIGIT_W-1:0] DIGIT_ONE = 4'h1;
  localparam logic [DIGIT_W-1:0] DIGIT_WRAP_UP = 4'h0;
  localparam logic [DIGIT_W-1:0] DIGIT_WRAP_DOWN = 4'hf;

  // reset values
  localparam logic [ACC_W-1:0] ACC_RST = 4'h0;
  localparam logic [D_W-1:0] D_RST = 3'h0;
  localparam logic [BANK_W-1:0] BANK_RST = 2'h0;
  localparam logic [FILE_W-1:0] FILE_RST = 4'h0;
  localparam logic [DIGIT_W-1:0] DIGIT_RST = 4'h0;

  // register port
  localparam int REG_AW = 3;
  localparam int REG_DW = 4;
  localparam logic [REG_AW-1:0] REG_ACC = 3'h0;
  localparam logic [REG_AW-1:0] REG_FILE = 3'h1;
  localparam logic [REG_AW-1:0] REG_DIGIT = 3'h2;
  localparam logic [REG_AW-1:0] REG_BANK = 3'h3;
  localparam logic [REG_AW-1:0] REG_D = 3'h4;
  localparam logic [REG_AW-1:0] REG_STATUS = 3'h5;
  localparam int STAT_SKIP = 0;
  localparam int STAT_CHAIN = 1;

  // operations presented by the decoder
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_A_TO_D = 4'h1,
    OP_D_TO_A = 4'h2,
    OP_BANK_TO_A = 4'h3,
    OP_FILE_TO_A = 4'h4,
    OP_SI_TO_A = 4'h5,
    OP_LOAD_POINTER_PAIR = 4'h6,
    OP_LOAD_BANK = 4'h7,
    OP_DIGIT_INC = 4'h8,
    OP_DIGIT_DEC = 4'h9,
    OP_RAM_LOAD = 4'ha,
    OP_RAM_XCHG = 4'hb,
    OP_XCHG_DEC = 4'hc,
    OP_XCHG_INC = 4'hd,
    OP_RAM_STORE = 4'he
  } op_e;

endpackage : nibble_exec_pkg

// >>> nibble_ram_if.sv
// port bundle between the transfer unit and its data ram
// assumes both ends run on the core clock
interface nibble_ram_if
  import nibble_exec_pkg::*;
  ();
  logic [RAM_AW-1:0] addr;
  logic [ACC_W-1:0] wdata;
  logic we;
  logic [ACC_W-1:0] rdata;

  modport master (output addr, output wdata, output we, input rdata);
  modport slave (input addr, input wdata, input we, output rdata);
endinterface : nibble_ram_if

// >>> nibble_data_ram.sv
// nibble-wide data ram, write on the clock edge, read without delay
// assumes the master holds addr steady through the cycle it reads or writes
module nibble_data_ram
  import nibble_exec_pkg::*;
  #(
    parameter int AW = RAM_AW
  ) (
  // clock
  input wire logic clk,
  // access from the transfer unit
  nibble_ram_if.slave ram
);

  logic [ACC_W-1:0] mem [0:(1<<AW)-1];

  // read path is combinational so an exchange finishes in one cycle
  assign ram.rdata = mem[ram.addr];

  // contents are not reset, as in the core
  always_ff @(posedge clk) begin
    if (ram.we) begin
      mem[ram.addr] <= ram.wdata;
    end
  end

endmodule : nibble_data_ram

// >>> nibble_register_ram_transfer_exec.sv
// transfer and ram-addressing execution unit of a 4-bit core, with its data ram
// assumes the decoder and stack logic share clk and present one instruction per cycle
//
// Behaviour
// - accumulator-to-D copies acc bits 2..0 into D, acc unchanged.
// - D-to-accumulator puts D in acc bits 2..0, acc bit 3 cleared.
// - bank-to-accumulator puts bank in acc bits 1..0, bits 3..2 cleared.
// - file-select-to-accumulator copies all four file-select bits into acc.
// - stack-index-to-accumulator puts stack index in acc bits 2..0, bit 3 zero.
// - pointer-pair load writes x into file-select and y into digit-select.
// - in a run of pointer-pair loads only the first one executes.
// - bank load writes the z field into bank-select.
// - digit increment adds one; skip the next instruction when result is 0.
// - digit decrement subtracts one; skip the next instruction when result is 15.
// - ram load copies pointed nibble to acc, then file-select XOR j.
// - ram exchange swaps acc and pointed nibble, then file-select XOR j.
// - exchange-decrement swaps, XORs file-select, decrements digit, skips on 15.
// - exchange-increment swaps, XORs file-select, increments digit, skips on 0.
// - ram store writes acc to pointed nibble, then file-select XOR j.
module nibble_register_ram_transfer_exec
  import nibble_exec_pkg::*;
  #(
    parameter int BANK_BITS = BANK_W
  ) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // instruction from the decoder
  input wire logic instr_valid,
  input wire op_e instr_op,
  input wire logic [IMM_W-1:0] instr_imm,
  // stack index from the stack logic
  input wire logic [SI_W-1:0] stack_index,
  // register port
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [REG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [REG_DW-1:0] reg_rdata,
  // architectural state
  output logic [ACC_W-1:0] acc,
  output logic [D_W-1:0] d_reg,
  output logic [FILE_W-1:0] file_sel,
  output logic [DIGIT_W-1:0] digit_sel,
  output logic [BANK_BITS-1:0] bank_sel,
  // instruction outcome
  output logic skip_pending,
  output logic instr_skipped
);

  // ram connection
  nibble_ram_if ram ();

  logic pointer_chain;
  logic [ACC_W-1:0] next_acc;
  logic [D_W-1:0] next_d;
  logic [FILE_W-1:0] next_file;
  logic [DIGIT_W-1:0] next_digit;
  logic [BANK_BITS-1:0] next_bank;
  logic next_skip;

  // data ram, addressed by the data pointer
  nibble_data_ram #(
    .AW(BANK_BITS + FILE_W + DIGIT_W)
  ) u_ram (
    .clk(clk),
    .ram(ram.slave)
  );

  // operation decode
  wire is_lpp = (instr_op == OP_LOAD_POINTER_PAIR);
  wire is_xchg_dec = (instr_op == OP_XCHG_DEC);
  wire is_xchg_inc = (instr_op == OP_XCHG_INC);
  wire is_xchg = (instr_op == OP_RAM_XCHG) || is_xchg_dec || is_xchg_inc;
  wire is_ram_load = (instr_op == OP_RAM_LOAD);
  wire is_ram_store = (instr_op == OP_RAM_STORE);
  wire is_inc = (instr_op == OP_DIGIT_INC) || is_xchg_inc;
  wire is_dec = (instr_op == OP_DIGIT_DEC) || is_xchg_dec;
  wire touches_ram = is_xchg || is_ram_load || is_ram_store;

  // an instruction is dropped when a skip is owed or it continues a load run
  wire chain_skip = is_lpp && pointer_chain;
  wire drop = skip_pending || chain_skip;
  wire run = instr_valid && !drop;

  // immediate fields
  wire [FILE_W-1:0] imm_x = instr_imm[IMM_X_HI:IMM_X_LO];
  wire [DIGIT_W-1:0] imm_y = instr_imm[IMM_Y_HI:IMM_Y_LO];
  wire [BANK_BITS-1:0] imm_z = instr_imm[IMM_Z_HI-:BANK_BITS];
  wire [FILE_W-1:0] imm_j = instr_imm[IMM_J_HI-:FILE_W];

  // pointer arithmetic, modulo 16 by width
  wire [DIGIT_W-1:0] digit_up = digit_sel + DIGIT_ONE;
  wire [DIGIT_W-1:0] digit_down = digit_sel - DIGIT_ONE;
  wire [FILE_W-1:0] file_xor = file_sel ^ imm_j;

  // skip owed to the next instruction
  wire inc_skip = is_inc && (digit_up == DIGIT_WRAP_UP);
  wire dec_skip = is_dec && (digit_down == DIGIT_WRAP_DOWN);

  // zero-extended narrow sources for the accumulator
  wire [ACC_W-1:0] d_wide = {1'b0, d_reg};
  wire [ACC_W-1:0] bank_wide = {{(ACC_W-BANK_BITS){1'b0}}, bank_sel};
  wire [ACC_W-1:0] si_wide = {1'b0, stack_index};

  // data pointer to the ram
  assign ram.addr = {bank_sel, file_sel, digit_sel};
  assign ram.wdata = acc;
  assign ram.we = run && (is_xchg || is_ram_store);

  // register port decode
  wire wr_acc = reg_wr && (reg_addr == REG_ACC);
  wire wr_file = reg_wr && (reg_addr == REG_FILE);
  wire wr_digit = reg_wr && (reg_addr == REG_DIGIT);
  wire wr_bank = reg_wr && (reg_addr == REG_BANK);
  wire wr_d = reg_wr && (reg_addr == REG_D);

  // status word for read-back
  wire [REG_DW-1:0] status_word = {{(REG_DW-2){1'b0}}, pointer_chain, skip_pending};

  // read mux, unmapped offsets read zero
  wire [REG_DW-1:0] rd_mux =
    (reg_addr == REG_ACC) ? acc :
    (reg_addr == REG_FILE) ? file_sel :
    (reg_addr == REG_DIGIT) ? digit_sel :
    (reg_addr == REG_BANK) ? bank_wide :
    (reg_addr == REG_D) ? d_wide :
    (reg_addr == REG_STATUS) ? status_word :
    {REG_DW{1'b0}};

  // accumulator next value; an executing instruction beats a port write
  always_comb begin
    next_acc = acc;
    if (run) begin
      case (instr_op)
        OP_D_TO_A: next_acc = d_wide;
        OP_BANK_TO_A: next_acc = bank_wide;
        OP_FILE_TO_A: next_acc = file_sel;
        OP_SI_TO_A: next_acc = si_wide;
        OP_RAM_LOAD: next_acc = ram.rdata;
        OP_RAM_XCHG: next_acc = ram.rdata;
        OP_XCHG_DEC: next_acc = ram.rdata;
        OP_XCHG_INC: next_acc = ram.rdata;
        default: next_acc = acc;
      endcase
    end else if (wr_acc && !instr_valid) begin
      next_acc = reg_wdata;
    end
  end

  // D register next value
  always_comb begin
    next_d = d_reg;
    if (run && instr_op == OP_A_TO_D) begin
      next_d = acc[D_W-1:0];
    end else if (wr_d && !instr_valid) begin
      next_d = reg_wdata[D_W-1:0];
    end
  end

  // file-select next value
  always_comb begin
    next_file = file_sel;
    if (run && is_lpp) begin
      next_file = imm_x;
    end else if (run && touches_ram) begin
      next_file = file_xor;
    end else if (wr_file && !instr_valid) begin
      next_file = reg_wdata;
    end
  end

  // digit-select next value
  always_comb begin
    next_digit = digit_sel;
    if (run && is_lpp) begin
      next_digit = imm_y;
    end else if (run && is_inc) begin
      next_digit = digit_up;
    end else if (run && is_dec) begin
      next_digit = digit_down;
    end else if (wr_digit && !instr_valid) begin
      next_digit = reg_wdata;
    end
  end

  // bank-select next value
  always_comb begin
    next_bank = bank_sel;
    if (run && instr_op == OP_LOAD_BANK) begin
      next_bank = imm_z;
    end else if (wr_bank && !instr_valid) begin
      next_bank = reg_wdata[BANK_BITS-1:0];
    end
  end

  // skip flag: set by a wrapping step, cleared by the instruction it swallows
  always_comb begin
    next_skip = skip_pending;
    if (instr_valid) begin
      next_skip = run && (inc_skip || dec_skip);
    end
  end

  // accumulator
  always_ff @(posedge clk) begin
    if (!reset_n) acc <= ACC_RST;
    else acc <= next_acc;
  end

  // D register
  always_ff @(posedge clk) begin
    if (!reset_n) d_reg <= D_RST;
    else d_reg <= next_d;
  end

  // file-select pointer
  always_ff @(posedge clk) begin
    if (!reset_n) file_sel <= FILE_RST;
    else file_sel <= next_file;
  end

  // digit-select pointer
  always_ff @(posedge clk) begin
    if (!reset_n) digit_sel <= DIGIT_RST;
    else digit_sel <= next_digit;
  end

  // bank-select pointer
  always_ff @(posedge clk) begin
    if (!reset_n) bank_sel <= BANK_RST[BANK_BITS-1:0];
    else bank_sel <= next_bank;
  end

  // owed skip
  always_ff @(posedge clk) begin
    if (!reset_n) skip_pending <= 1'b0;
    else skip_pending <= next_skip;
  end

  // remembers that the last instruction seen was a pointer-pair load
  always_ff @(posedge clk) begin
    if (!reset_n) pointer_chain <= 1'b0;
    else if (instr_valid) pointer_chain <= is_lpp;
  end

  // one-cycle mark that the previous instruction was swallowed
  always_ff @(posedge clk) begin
    if (!reset_n) instr_skipped <= 1'b0;
    else instr_skipped <= instr_valid && drop;
  end

  // read data, valid the cycle after the read strobe only
  always_ff @(posedge clk) begin
    if (!reset_n) reg_rdata <= {REG_DW{1'b0}};
    else if (reg_rd) reg_rdata <= rd_mux;
    else reg_rdata <= {REG_DW{1'b0}};
  end

endmodule : nibble_register_ram_transfer_exec

// >>> nibble_exec_chk.sv
// port-level assertions for the nibble transfer unit
// assumes it is bound to the top module and sees only its ports
module nibble_exec_chk
  import nibble_exec_pkg::*;
  #(parameter int BANK_BITS = BANK_W) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // instruction and stack index
  input wire logic instr_valid,
  input wire op_e instr_op,
  input wire logic [IMM_W-1:0] instr_imm,
  input wire logic [SI_W-1:0] stack_index,
  // architectural state
  input wire logic [ACC_W-1:0] acc,
  input wire logic [D_W-1:0] d_reg,
  input wire logic [FILE_W-1:0] file_sel,
  input wire logic [DIGIT_W-1:0] digit_sel,
  input wire logic [BANK_BITS-1:0] bank_sel,
  input wire logic skip_pending,
  input wire logic instr_skipped
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // an instruction that no owed skip swallows
  logic exec;
  logic ptr_op;
  assign exec = instr_valid && !skip_pending;
  assign ptr_op = instr_valid && instr_op == OP_LOAD_POINTER_PAIR;
  // load run: a non-load followed by an executed load, or two loads in a row
  sequence s_lpp_first;
    instr_valid && !ptr_op ##1 exec && ptr_op;
  endsequence
  sequence s_lpp_run;
    ptr_op ##1 ptr_op;
  endsequence
  property p_a2d;
    exec && instr_op == OP_A_TO_D |=> d_reg == $past(acc[2:0]) && $stable(acc);
  endproperty
  a_a2d: assert property (p_a2d) else $error("acc to d wrong");
  property p_d2a;
    exec && instr_op == OP_D_TO_A |=> acc == {1'b0, $past(d_reg)};
  endproperty
  a_d2a: assert property (p_d2a) else $error("d to acc wrong");
  property p_b2a;
    exec && instr_op == OP_BANK_TO_A |=> acc == ACC_W'($past(bank_sel));
  endproperty
  a_b2a: assert property (p_b2a) else $error("bank to acc wrong");
  property p_f2a;
    exec && instr_op == OP_FILE_TO_A |=> acc == $past(file_sel);
  endproperty
  a_f2a: assert property (p_f2a) else $error("file to acc wrong");
  property p_si2a;
    exec && instr_op == OP_SI_TO_A |=> acc == {1'b0, $past(stack_index)};
  endproperty
  a_si2a: assert property (p_si2a) else $error("stack index to acc wrong");
  property p_lpp;
    s_lpp_first |=> file_sel == $past(instr_imm[7:4]) && digit_sel == $past(instr_imm[3:0]);
  endproperty
  a_lpp: assert property (p_lpp) else $error("pointer pair load wrong");
  property p_run;
    s_lpp_run |=> instr_skipped && $stable(file_sel) && $stable(digit_sel);
  endproperty
  a_run: assert property (p_run) else $error("second pointer load ran");
  property p_bank;
    exec && instr_op == OP_LOAD_BANK |=> bank_sel == $past(instr_imm[BANK_BITS-1:0]);
  endproperty
  a_bank: assert property (p_bank) else $error("bank load wrong");
  property p_inc;
    exec && instr_op inside {OP_DIGIT_INC, OP_XCHG_INC} |=>
      digit_sel == $past(digit_sel) + DIGIT_ONE && skip_pending == (digit_sel == DIGIT_WRAP_UP);
  endproperty
  a_inc: assert property (p_inc) else $error("digit increment wrong");
  property p_dec;
    exec && instr_op inside {OP_DIGIT_DEC, OP_XCHG_DEC} |=>
      digit_sel == $past(digit_sel) - DIGIT_ONE && skip_pending == (digit_sel == DIGIT_WRAP_DOWN);
  endproperty
  a_dec: assert property (p_dec) else $error("digit decrement wrong");
  property p_xor;
    exec && instr_op inside {OP_RAM_LOAD, OP_RAM_XCHG, OP_XCHG_DEC, OP_XCHG_INC, OP_RAM_STORE}
      |=> file_sel == ($past(file_sel) ^ $past(instr_imm[3:0]));
  endproperty
  a_xor: assert property (p_xor) else $error("file select xor wrong");
  property p_skip;
    instr_valid && skip_pending |=> instr_skipped && !skip_pending && $stable(acc)
      && $stable(file_sel) && $stable(digit_sel);
  endproperty
  a_skip: assert property (p_skip) else $error("skipped instruction acted");
endmodule : nibble_exec_chk

bind nibble_register_ram_transfer_exec nibble_exec_chk #(.BANK_BITS(BANK_BITS)) chk (
  .clk, .reset_n, .instr_valid, .instr_op, .instr_imm, .stack_index, .acc, .d_reg,
  .file_sel, .digit_sel, .bank_sel, .skip_pending, .instr_skipped);

// >>> nibble_stack_model.sv
// stand-in for the stack logic that feeds the stack index
// assumes the bench loads a value with a one-cycle strobe on the core clock
module nibble_stack_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // load request
  input wire logic load,
  input wire logic [2:0] load_val,
  // index shown to the unit
  output logic [2:0] stack_index
);
  // index register, cleared by reset
  always_ff @(posedge clk) begin
    if (!reset_n) stack_index <= 3'h0;
    else if (load) stack_index <= load_val;
  end
endmodule : nibble_stack_model

// >>> nibble_register_ram_transfer_exec_tb.sv
// self-checking bench for the nibble transfer unit
// assumes the unit holds its own data ram and a stack model feeds the index
module nibble_register_ram_transfer_exec_tb import nibble_exec_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, instr_valid, reg_wr, reg_rd, skip_pending, instr_skipped, si_load;
  op_e instr_op;
  logic [7:0] instr_imm;
  logic [2:0] stack_index, si_val, reg_addr, d_reg;
  logic [3:0] reg_wdata, reg_rdata, acc, file_sel, digit_sel;
  logic [1:0] bank_sel;
  int mismatches, checked, cycles;
  nibble_stack_model stk (.clk(clk), .reset_n(reset_n), .load(si_load), .load_val(si_val),
    .stack_index(stack_index));
  nibble_register_ram_transfer_exec dut (.clk(clk), .reset_n(reset_n),
    .instr_valid(instr_valid), .instr_op(instr_op), .instr_imm(instr_imm),
    .stack_index(stack_index), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc(acc), .d_reg(d_reg), .file_sel(file_sel),
    .digit_sel(digit_sel), .bank_sel(bank_sel), .skip_pending(skip_pending),
    .instr_skipped(instr_skipped));
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one instruction cycle, then let the edge settle
  task automatic ex(input op_e op, input logic [7:0] imm);
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_imm <= imm;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask : ex
  task automatic wr(input logic [2:0] a, input logic [3:0] v);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [3:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", e, reg_rdata);
  endtask : rd
  // pointer pair run, bank load, reads of bank and file
  task automatic t_pointers();
    ex(OP_LOAD_POINTER_PAIR, 8'h5c);
    ex(OP_LOAD_POINTER_PAIR, 8'h12);
    chk("instr_skipped", 8'h01, instr_skipped);
    chk("file_sel", 8'h05, file_sel);
    chk("digit_sel", 8'h0c, digit_sel);
    rd(REG_STATUS, 4'h2);
    rd(REG_DIGIT, 4'hc);
    ex(OP_LOAD_BANK, 8'hf3);
    chk("bank_sel", 8'h03, bank_sel);
    rd(REG_BANK, 4'h3);
    wr(REG_ACC, 4'hf);
    ex(OP_BANK_TO_A, 8'h00);
    chk("acc", 8'h03, acc);
    ex(OP_FILE_TO_A, 8'h00);
    chk("acc", 8'h05, acc);
    rd(REG_FILE, 4'h5);
    rd(3'h7, 4'h0);
  endtask : t_pointers
  // store, load and exchange through two file pointers
  task automatic t_ram();
    wr(REG_ACC, 4'h9);
    ex(OP_RAM_STORE, 8'h00);
    wr(REG_ACC, 4'h0);
    ex(OP_RAM_LOAD, 8'h05);
    chk("acc", 8'h09, acc);
    chk("file_sel", 8'h00, file_sel);
    wr(REG_ACC, 4'h2);
    ex(OP_RAM_STORE, 8'h05);
    chk("file_sel", 8'h05, file_sel);
    ex(OP_RAM_XCHG, 8'h05);
    chk("acc", 8'h09, acc);
    chk("file_sel", 8'h00, file_sel);
    ex(OP_RAM_LOAD, 8'h00);
    chk("acc", 8'h02, acc);
    wr(REG_FILE, 4'h5);
    wr(REG_ACC, 4'h0);
    ex(OP_RAM_LOAD, 8'h00);
    chk("acc", 8'h02, acc);
  endtask : t_ram
  // digit steps with skips at both wrap points
  task automatic t_digit();
    ex(OP_LOAD_POINTER_PAIR, 8'h5f);
    ex(OP_DIGIT_INC, 8'h00);
    chk("skip_pending", 8'h01, {digit_sel, 3'h0, skip_pending});
    rd(REG_STATUS, 4'h1);
    ex(OP_FILE_TO_A, 8'h00);
    chk("skip acc", 8'h12, {instr_skipped, acc});
    ex(OP_DIGIT_DEC, 8'h00);
    chk("skip_pending", 8'hf1, {digit_sel, 3'h0, skip_pending});
    ex(OP_LOAD_POINTER_PAIR, 8'h00);
    chk("skip digit", 8'h1f, {instr_skipped, digit_sel});
    ex(OP_DIGIT_DEC, 8'h00);
    chk("skip_pending", 8'he0, {digit_sel, 3'h0, skip_pending});
    ex(OP_DIGIT_INC, 8'h00);
    chk("skip_pending", 8'hf0, {digit_sel, 3'h0, skip_pending});
    wr(REG_ACC, 4'h7);
    ex(OP_RAM_STORE, 8'h00);
    wr(REG_ACC, 4'h1);
    ex(OP_XCHG_INC, 8'h03);
    chk("acc file", 8'h76, {acc, file_sel});
    chk("skip_pending", 8'h01, {digit_sel, 3'h0, skip_pending});
    ex(OP_NONE, 8'h00);
    ex(OP_RAM_STORE, 8'h00);
    wr(REG_ACC, 4'h4);
    ex(OP_XCHG_DEC, 8'h06);
    chk("acc file", 8'h70, {acc, file_sel});
    chk("skip_pending", 8'hf1, {digit_sel, 3'h0, skip_pending});
    ex(OP_NONE, 8'h00);
  endtask : t_digit
  // d register and stack index transfers
  task automatic t_transfers();
    wr(REG_ACC, 4'hd);
    ex(OP_A_TO_D, 8'h00);
    chk("d acc", 8'h5d, {1'b0, d_reg, acc});
    ex(OP_D_TO_A, 8'h00);
    chk("acc", 8'h05, acc);
    rd(REG_D, 4'h5);
    si_val <= 3'h7;
    si_load <= 1'b1;
    @(posedge clk);
    si_load <= 1'b0;
    wr(REG_ACC, 4'hf);
    ex(OP_SI_TO_A, 8'h00);
    chk("acc", 8'h07, acc);
  endtask : t_transfers
  initial begin
    {reset_n, instr_valid, reg_wr, reg_rd, si_load} = '0;
    instr_op = OP_NONE;
    {instr_imm, reg_addr, reg_wdata, si_val} = '0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    t_pointers();
    t_ram();
    t_digit();
    t_transfers();
    complete_run();
  end
endmodule : nibble_register_ram_transfer_exec_tb
